// file: verilog/bss_regs.svh
/*
 beam scan sequencer constants: timing figures and derived cycle counts.
 assumes a 100 MHz clock; included by bare name, definitions only.
*/
`ifndef BSS_REGS_SVH
`define BSS_REGS_SVH
// ---------------------------------------------------------------------------
// timing figures
// ---------------------------------------------------------------------------
`define BSS_CLK_MHZ 100
`define BSS_SLOT_US 30
`define BSS_OVERHEAD_US 400
`define BSS_FLOOR_US 1000
// cycle counts derived from the figures and the clock rate
`define BSS_SLOT_CYC (`BSS_SLOT_US * `BSS_CLK_MHZ)
`define BSS_OVERHEAD_CYC (`BSS_OVERHEAD_US * `BSS_CLK_MHZ)
`define BSS_FLOOR_CYC (`BSS_FLOOR_US * `BSS_CLK_MHZ)
`define BSS_BEAMS_DEF 192
`define BSS_THRESH_W 12
`endif

// file: verilog/bss_pkg.sv
/*
 beam scan sequencer types.
 assumes nothing beyond the constants header.
*/
`default_nettype none
package bss_pkg;
    // sequencer states
    typedef enum logic [1:0] {
        BSS_ST_FIRE,
        BSS_ST_OVERHEAD,
        BSS_ST_IDLE
    } bss_state_t;
endpackage
`default_nettype wire

// file: verilog/bss_sync.sv
/*
 two flip-flop level synchroniser for one bit.
 assumes the input is asynchronous to ref_clk_in.
*/
`timescale 1ns/10ps
`default_nettype none
module bss_sync (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic clk_en_in,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_q;
    // first stage feeds only the second stage
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            meta_q <= 1'h0;
            sync_out <= 1'h0;
        end else if (clk_en_in) begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

// file: verilog/bss_top.sv
/*
 beam scan sequencer: fires one transmitter at a time, enables the matching
 receiver, compares its power with a threshold and hands out the result
 once per fixed scan period.
 assumes receiver power arrives as a same-clock word; the power-valid
 strobe is unused since sampling occurs at the end of each slot.
*/
`timescale 1ns/10ps
`default_nettype none
`include "bss_regs.svh"
// What this block does
// - scan beams strictly one after another
// - fire one transmitter, enable only its receiver
// - beam active when power exceeds threshold
// - fixed 30 us slot per beam
// - period is beams times slot plus overhead
// - period never shorter than 1 ms
// - hand result out once per period
module bss_top
    import bss_pkg::*;
#(
    parameter int BEAMS = `BSS_BEAMS_DEF,
    parameter int SLOT_CYC = `BSS_SLOT_CYC,
    parameter int OVERHEAD_CYC = `BSS_OVERHEAD_CYC,
    parameter int FLOOR_CYC = `BSS_FLOOR_CYC
) (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic clk_en_in,
    input wire logic [`BSS_THRESH_W-1:0] rx_power_in,
    input wire logic [`BSS_THRESH_W-1:0] threshold_in,
    input wire logic scan_enable_in,
    output logic [BEAMS-1:0] tx_fire_out,
    output logic [BEAMS-1:0] rx_enable_out,
    output logic [BEAMS-1:0] result_out,
    output logic result_valid_out,
    output logic scan_active_out
);
    // ------------------------------------------------------------------------
    // derived counts
    // ------------------------------------------------------------------------
    localparam int IDX_W = (BEAMS > 1) ? $clog2(BEAMS) : 1;
    localparam int SCAN_CYC = BEAMS * SLOT_CYC + OVERHEAD_CYC;
    localparam int PAD_CYC = (SCAN_CYC < FLOOR_CYC) ? (FLOOR_CYC - SCAN_CYC) : 0;
    localparam int CNT_W = $clog2(FLOOR_CYC + OVERHEAD_CYC + SLOT_CYC + 1);
    // idle always spends one edge, so it stands as the last overhead cycle
    localparam int OVH_LAST = OVERHEAD_CYC - 2;

    // ------------------------------------------------------------------------
    // elaboration checks on parameter values
    // ------------------------------------------------------------------------
    // at least one beam is needed to form a frame
    if (BEAMS < 1) begin : g_chk_beams
        $error("bss_top: BEAMS must be at least one");
    end
    // the slot end test needs a slot of two cycles or more
    if (SLOT_CYC < 2) begin : g_chk_slot
        $error("bss_top: SLOT_CYC must be at least two");
    end
    // one overhead cycle sits in the overhead state, one in idle
    if (OVERHEAD_CYC < 2) begin : g_chk_ovh
        $error("bss_top: OVERHEAD_CYC must be at least two");
    end
    // the floor must be a positive count
    if (FLOOR_CYC < 1) begin : g_chk_floor
        $error("bss_top: FLOOR_CYC must be at least one");
    end
    // counter and index beyond 32 bits are not served
    if (CNT_W > 32 || IDX_W > 32) begin : g_chk_width
        $error("bss_top: counts too large for the cycle counter");
    end

    // ------------------------------------------------------------------------
    // enable synchroniser (pin from outside)
    // ------------------------------------------------------------------------
    logic scan_en_s;
    bss_sync u_en_sync (
        .ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .clk_en_in(clk_en_in),
        .async_in(scan_enable_in),
        .sync_out(scan_en_s)
    );

    // one-hot select of a beam index
    function automatic logic [BEAMS-1:0] bss_onehot(input logic [IDX_W-1:0] idx);
        bss_onehot = '0;
        bss_onehot[idx] = 1'h1;
    endfunction

    // ------------------------------------------------------------------------
    // sequencer state
    // ------------------------------------------------------------------------
    // sequencer position and the frame gathered so far
    bss_state_t state_q;
    logic [IDX_W-1:0] beam_q;
    logic [CNT_W-1:0] cnt_q;
    logic [BEAMS-1:0] work_q;
    logic [BEAMS-1:0] sel_d;
    logic slot_end;
    logic last_beam;
    logic beam_hit;
    logic start_go;

    // slot and beam end decode, and the threshold test
    assign slot_end = (cnt_q == CNT_W'(SLOT_CYC - 1));
    assign last_beam = (beam_q == IDX_W'(BEAMS - 1));
    assign beam_hit = (rx_power_in > threshold_in);
    // idle may leave once the pad is served and the scan is enabled
    assign start_go = (state_q == BSS_ST_IDLE) && (cnt_q >= CNT_W'(PAD_CYC)) &&
        scan_en_s;

    // state, beam index and cycle counter
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            state_q <= BSS_ST_IDLE;
            beam_q <= '0;
            cnt_q <= '0;
        end else if (clk_en_in) begin
            unique case (state_q)
                BSS_ST_FIRE: begin
                    // count the slot; at its end go to the next beam or overhead
                    if (slot_end) begin
                        cnt_q <= '0;
                        if (last_beam) begin
                            state_q <= BSS_ST_OVERHEAD;
                        end else begin
                            beam_q <= beam_q + 1'h1;
                        end
                    end else begin
                        cnt_q <= cnt_q + 1'h1;
                    end
                end
                BSS_ST_OVERHEAD: begin
                    // stop one short: the idle edge completes the overhead
                    if (cnt_q == CNT_W'(OVH_LAST)) begin
                        cnt_q <= '0;
                        state_q <= BSS_ST_IDLE;
                    end else begin
                        cnt_q <= cnt_q + 1'h1;
                    end
                end
                BSS_ST_IDLE: begin
                    // pad out to the floor, then restart at beam one
                    if (start_go) begin
                        cnt_q <= '0;
                        beam_q <= '0;
                        state_q <= BSS_ST_FIRE;
                    end else if (cnt_q < CNT_W'(PAD_CYC)) begin
                        cnt_q <= cnt_q + 1'h1;
                    end
                end
                default: begin
                    // unused state code: fall back to idle
                    cnt_q <= '0;
                    state_q <= BSS_ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // optics drive: one transmitter and its receiver only
    // ------------------------------------------------------------------------
    // next drive pattern: beam one on start, the next beam at each slot end but the last
    always_comb begin
        sel_d = tx_fire_out;
        if (start_go) begin
            sel_d = bss_onehot('0);
        end else if (state_q != BSS_ST_FIRE) begin
            sel_d = '0;
        end else if (slot_end && last_beam) begin
            sel_d = '0;
        end else if (slot_end) begin
            sel_d = bss_onehot(beam_q + 1'h1);
        end
    end

    // transmitter and receiver registers follow the same pattern
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            tx_fire_out <= '0;
            rx_enable_out <= '0;
        end else if (clk_en_in) begin
            tx_fire_out <= sel_d;
            rx_enable_out <= sel_d;
        end
    end

    // ------------------------------------------------------------------------
    // evaluation and hand-over
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            work_q <= '0;
            result_out <= '0;
            result_valid_out <= 1'h0;
        end else if (clk_en_in) begin
            result_valid_out <= 1'h0;
            if (state_q == BSS_ST_FIRE && slot_end) begin
                work_q[beam_q] <= beam_hit;
                if (last_beam) begin
                    // last bit bypasses work_q, which only lands at this edge
                    result_out <= work_q;
                    result_out[beam_q] <= beam_hit;
                    result_valid_out <= 1'h1;
                end
            end
        end
    end

    // scan activity flag, one cycle behind the state
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            scan_active_out <= 1'h0;
        end else if (clk_en_in) begin
            scan_active_out <= (state_q != BSS_ST_IDLE);
        end
    end
endmodule
`default_nettype wire

// file: tb/bss_top_checker.sv
/* port assertions for the beam scan sequencer.
 assumes clk_en_in is held high. */
`timescale 1ns/10ps
`default_nettype none
module bss_top_checker #(
    parameter int BEAMS = 4,
    parameter int SLOT_CYC = 4,
    parameter int OVERHEAD_CYC = 10,
    parameter int FLOOR_CYC = 100
) (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic scan_enable_in,
    input wire logic [BEAMS-1:0] tx_fire_out,
    input wire logic [BEAMS-1:0] rx_enable_out,
    input wire logic [BEAMS-1:0] result_out,
    input wire logic result_valid_out,
    input wire logic scan_active_out
);
    localparam int SCAN = BEAMS * SLOT_CYC + OVERHEAD_CYC;
    localparam int PER = (SCAN > FLOOR_CYC) ? SCAN : FLOOR_CYC;
    logic [BEAMS-1:0] prev_q;
    int slot_q;
    int per_q;
    logic clean_q;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);
    // slot and period counters; clean_q marks a period run with enable high
    always_ff @(posedge ref_clk_in) begin
        prev_q <= tx_fire_out;
        slot_q <= (tx_fire_out == prev_q) ? slot_q + 1 : 1;
        per_q <= result_valid_out ? 1 : per_q + 1;
        clean_q <= reset_n_in && scan_enable_in && (result_valid_out || clean_q);
    end
    // hand-out: one pulse while all transmitters are dark
    sequence hand_s;
        result_valid_out && tx_fire_out == '0 ##1 !result_valid_out;
    endsequence
    one_beam_a: assert property ($onehot0(tx_fire_out)) else $error("two beams");
    rx_pair_a: assert property (rx_enable_out == tx_fire_out) else $error("rx pair");
    beam_order_a: assert property (
        tx_fire_out != 0 && $past(tx_fire_out) != 0 && $changed(tx_fire_out)
        |-> tx_fire_out == $past(tx_fire_out) << 1) else $error("beam order");
    slot_len_a: assert property (
        $past(tx_fire_out) != 0 && $changed(tx_fire_out) |-> slot_q == SLOT_CYC)
        else $error("slot length");
    hand_out_a: assert property (
        $fell(tx_fire_out[BEAMS-1]) |-> hand_s) else $error("no hand out");
    valid_lone_a: assert property (
        result_valid_out |-> $past(tx_fire_out[BEAMS-1])) else $error("stray pulse");
    frame_hold_a: assert property (
        !result_valid_out |-> $stable(result_out)) else $error("frame moved");
    period_len_a: assert property (
        result_valid_out && clean_q |-> per_q == PER) else $error("period");
    scan_flag_a: assert property (
        tx_fire_out != '0 |=> scan_active_out) else $error("scan flag");
endmodule
bind bss_top bss_top_checker #(.BEAMS(BEAMS), .SLOT_CYC(SLOT_CYC),
    .OVERHEAD_CYC(OVERHEAD_CYC), .FLOOR_CYC(FLOOR_CYC)) u_chk (.ref_clk_in, .reset_n_in,
    .scan_enable_in, .tx_fire_out, .rx_enable_out, .result_out, .result_valid_out,
    .scan_active_out);
`default_nettype wire

// file: tb/bss_beams.sv
/* receiver model: power of the enabled receiver.
 assumes the bench sets which beams are lit. */
`timescale 1ns/10ps
`default_nettype none
module bss_beams #(parameter int BEAMS = 4) (
    input wire logic ref_clk_in,
    input wire logic [BEAMS-1:0] rx_enable_in,
    input wire logic [BEAMS-1:0] lit_in,
    input wire logic [11:0] threshold_in,
    output logic [11:0] rx_power_out
);
    logic [11:0] last_q = 12'h000;
    // with no receiver enabled the line wanders instead of holding
    always_ff @(posedge ref_clk_in) begin
        last_q <= rx_power_out;
    end
    // lit beam reads one above threshold, dark beam exactly at it
    assign rx_power_out = (rx_enable_in == '0) ? ~last_q :
        ((rx_enable_in & lit_in) != '0) ? threshold_in + 12'h001 : threshold_in;
endmodule
`default_nettype wire

// file: tb/tb.sv
/* bench for the beam scan sequencer, four beams, short counts.
 assumes the receiver model and checker are compiled. */
`timescale 1ns/10ps
`default_nettype none
module tb;
    localparam int BEAMS = 4;
    localparam int PER = 100;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic en = 1'b0;
    logic [11:0] thr = 12'h800;
    logic [11:0] pwr;
    logic [BEAMS-1:0] lit = 4'h0;
    logic [BEAMS-1:0] tx, rx, res;
    logic vld;
    logic act;
    logic [BEAMS-1:0] rx2;
    logic [11:0] pwr2;
    int mismatches = 0;
    int checked = 0;
    // clock
    initial begin
        forever #5 clk = ~clk;
    end
    bss_beams #(.BEAMS(BEAMS)) u_beams (.ref_clk_in(clk), .rx_enable_in(rx),
        .lit_in(lit), .threshold_in(thr), .rx_power_out(pwr));
    bss_top #(.BEAMS(BEAMS), .SLOT_CYC(4), .OVERHEAD_CYC(10), .FLOOR_CYC(PER)) DUT (
        .ref_clk_in(clk), .reset_n_in(rst_n), .clk_en_in(1'b1), .rx_power_in(pwr),
        .threshold_in(thr), .scan_enable_in(en), .tx_fire_out(tx), .rx_enable_out(rx),
        .result_out(res), .result_valid_out(vld), .scan_active_out(act));
    // second sequencer whose beam time plus overhead exceeds the floor, judged by the checker
    bss_beams #(.BEAMS(BEAMS)) u_beams2 (.ref_clk_in(clk), .rx_enable_in(rx2),
        .lit_in(lit), .threshold_in(thr), .rx_power_out(pwr2));
    bss_top #(.BEAMS(BEAMS), .SLOT_CYC(4), .OVERHEAD_CYC(10), .FLOOR_CYC(20)) DUT_long (
        .ref_clk_in(clk), .reset_n_in(rst_n), .clk_en_in(1'b1), .rx_power_in(pwr2),
        .threshold_in(thr), .scan_enable_in(en), .tx_fire_out(), .rx_enable_out(rx2),
        .result_out(), .result_valid_out(), .scan_active_out());
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // count edges up to the next result pulse, bounded
    task automatic wait_pulse(output int n);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (vld !== 1'b1 && n < 3 * PER);
    endtask
    task automatic t_frames();
        logic [BEAMS-1:0] pats [5] = '{4'h0, 4'hf, 4'h5, 4'ha, 4'h8};
        int n;
        foreach (pats[i]) begin
            lit <= pats[i];
            wait_pulse(n);
            wait_pulse(n);
            chk("frame", pats[i], res);
            chk("period", PER, n);
        end
        $display("frames done");
    endtask
    task automatic t_stall();
        int n;
        en <= 1'b0;
        wait_pulse(n);
        chk("stalled", 3 * PER, n);
        chk("dark", 0, tx);
        chk("idle flag", 0, act);
        en <= 1'b1;
        wait_pulse(n);
        chk("resumed", 1, n < PER);
        $display("stall done");
    endtask
    task automatic t_reset();
        int n;
        repeat (PER - 10) @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        chk("reset tx", 0, tx);
        chk("reset frame", 0, res);
        rst_n <= 1'b1;
        wait_pulse(n);
        chk("frame after reset", lit, res);
        $display("reset done");
    endtask
    task automatic end_of_test();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        en <= 1'b1;
        t_frames();
        t_stall();
        t_reset();
        end_of_test();
    end
    // watchdog
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        end_of_test();
    end
endmodule
`default_nettype wire
